/* File: shared/aas_pkg.sv */
// Package for the alarm annunciator sequencer: timing counts and encodings.
// Assumes a 20 MHz system clock; included by the sequencer and its event memory.
package aas_pkg;
   localparam int unsigned CLK_HZ          = 20000000;
   localparam int unsigned NUM_POINTS      = 16;
   localparam int unsigned DEBOUNCE_MS     = 10;
   localparam int unsigned DEBOUNCE_CYC    = (CLK_HZ / 1000) * DEBOUNCE_MS;
   localparam int unsigned FLASH_HALF_MS   = 250;
   localparam int unsigned FLASH_HALF_CYC  = (CLK_HZ / 1000) * FLASH_HALF_MS;
   localparam int unsigned EVENT_DEPTH     = 8;
   localparam int unsigned EVENT_MIN       = 5;
   localparam int unsigned EVT_W           = 8;
   localparam int unsigned EVT_PT_LSB      = 0;
   localparam int unsigned EVT_KIND_LSB    = 4;
   localparam int unsigned SUP_HOLD_CYC    = 1024;
   localparam logic [2:0]  EVT_KIND_ALERT  = 3'h1;
   localparam logic [2:0]  EVT_KIND_CLEAR  = 3'h2;
   localparam logic [2:0]  EVT_KIND_RESET  = 3'h3;
   localparam logic        EVT_RESERVED    = 1'h0;

   typedef enum logic [1:0] {
      AAS_NORMAL,
      AAS_ALERT,
      AAS_ACKED
   } aas_state_e;
endpackage : aas_pkg

/* File: verilog/aas_event_mem.sv */
// Event history memory for the alarm annunciator sequencer.
// Assumes one write port and two registered read ports on the system clock.
`timescale 1ns/1ps
module aas_event_mem
   import aas_pkg::*;
#(
   parameter int unsigned DEPTH = EVENT_DEPTH,
   parameter int unsigned WIDTH = EVT_W,
   parameter int unsigned AW    = $clog2(DEPTH)
) (
   input  wire logic             i_clk_sys,
   input  wire logic             i_we,
   input  wire logic [AW-1:0]    i_waddr,
   input  wire logic [WIDTH-1:0] i_wdata,
   input  wire logic [AW-1:0]    i_raddr_a,
   output logic      [WIDTH-1:0] o_rdata_a,
   input  wire logic [AW-1:0]    i_raddr_b,
   output logic      [WIDTH-1:0] o_rdata_b
);
   logic [WIDTH-1:0] mem [DEPTH];

   // Write and registered reads
   always_ff @(posedge i_clk_sys) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata_a <= mem[i_raddr_a];
      o_rdata_b <= mem[i_raddr_b];
   end
endmodule : aas_event_mem

/* File: verilog/aas_sequencer.sv */
// Manual lamp-reset annunciator sequencer with sixteen points and event history.
// Assumes raw contacts and pushbuttons from outside; one 20 MHz clock, sync reset.
//
// Summary of operation
// RQ1: Sixteen points, own lamp and state each.
// RQ2: Per-point polarity selects closed or open alarm.
// RQ3: Separate silence, acknowledge, reset, test pushbuttons.
// RQ4: New trouble: flash lamp, pilot, horn.
// RQ5: Acknowledge: steady lamps, horn and pilot off.
// RQ6: Lamp reset clears acked point once trouble gone.
// RQ7: Cleared before acknowledge keeps flashing, horn on.
// RQ8: Lamp reset press or release never sounds horn.
// RQ9: Points sequence independently of each other.
// RQ10: Wrong button combinations cannot corrupt states.
// RQ11: Test simulates all inputs through point logic.
// RQ12: Event history keeps newest five or more.
// RQ13: History readable by panel and serial paths.
// RQ14: Horn relay output drives shared common horn.
// RQ15: Self supervision flags a failed check.
// RQ16: Inputs synchronised and debounced before use; i_psu_ok and i_alarm_on_open are used directly, without either.
// RQ17: One common in-phase flash timebase.
`timescale 1ns/1ps
module aas_sequencer
   import aas_pkg::*;
#(
   parameter int unsigned NP        = NUM_POINTS,
   parameter int unsigned DEB_CYC   = DEBOUNCE_CYC,
   parameter int unsigned FLASH_CYC = FLASH_HALF_CYC,
   parameter int unsigned DEPTH     = EVENT_DEPTH,
   parameter int unsigned AW        = $clog2(DEPTH)
) (
   input  wire logic             i_clk_sys,
   input  wire logic             i_reset_n,
   input  wire logic [NP-1:0]    i_contact,
   input  wire logic [NP-1:0]    i_alarm_on_open,
   input  wire logic             i_pb_silence,
   input  wire logic             i_pb_ack,
   input  wire logic             i_pb_lamp_reset,
   input  wire logic             i_pb_lamp_test,
   input  wire logic             i_psu_ok,
   input  wire logic [AW-1:0]    i_panel_idx,
   input  wire logic [AW-1:0]    i_serial_idx,
   output logic      [NP-1:0]    o_lamp,
   output logic                  o_pilot_lamp,
   output logic                  o_horn_relay,
   output logic                  o_sup_fault,
   output logic      [EVT_W-1:0] o_panel_event,
   output logic      [EVT_W-1:0] o_serial_event,
   output logic      [AW:0]      o_event_count
);
   localparam int unsigned NIN = NP + 4;
   localparam int unsigned DW  = $clog2(DEB_CYC + 1);
   localparam int unsigned FW  = $clog2(FLASH_CYC + 1);
   localparam int unsigned PW  = $clog2(NP);

   // Memory address of a newest-relative slot
   function automatic logic [AW-1:0] slot_addr(input logic [AW-1:0] wp,
                                               input logic [AW-1:0] idx);
      slot_addr = wp - AW'(1) - idx;
   endfunction : slot_addr

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers and debouncers
   logic [NIN-1:0]         sync1;
   logic [NIN-1:0]         sync2;
   logic [NIN-1:0]         deb;
   logic [NIN-1:0]         next_deb;
   logic [DW-1:0]          deb_cnt [NIN];
   logic [DW-1:0]          next_deb_cnt [NIN];
   logic [NIN-1:0]         raw_in;

   assign raw_in = {i_pb_lamp_test, i_pb_lamp_reset, i_pb_ack, i_pb_silence, i_contact};  // [RQ3]

   // Debounce: a level must hold DEB_CYC cycles to be accepted
   always_comb begin
      for (int i = 0; i < NIN; i++) begin
         next_deb[i]     = deb[i];
         next_deb_cnt[i] = '0;
         if (sync2[i] != deb[i]) begin
            if (deb_cnt[i] == DW'(DEB_CYC - 1)) begin
               next_deb[i] = sync2[i];  // [RQ16]
            end else begin
               next_deb_cnt[i] = deb_cnt[i] + DW'(1);
            end
         end
      end
   end

   // Two-stage synchroniser, then debounce state
   always_ff @(posedge i_clk_sys) begin
      sync1 <= raw_in;  // [RQ16]
      sync2 <= sync1;
      if (!i_reset_n) begin
         deb <= {4'h0, i_alarm_on_open};  // Idle contact level, no false alert
         for (int i = 0; i < NIN; i++) begin
            deb_cnt[i] <= '0;
         end
      end else begin
         deb <= next_deb;
         for (int i = 0; i < NIN; i++) begin
            deb_cnt[i] <= next_deb_cnt[i];
         end
      end
   end

   logic [NP-1:0] contact_db;
   logic          silence_db;
   logic          ack_db;
   logic          reset_db;
   logic          test_db;
   logic          reset_prev;
   logic          reset_press;
   logic          ack_prev;
   logic          ack_press;
   logic [NP-1:0] trouble;

   assign contact_db  = deb[NP-1:0];
   assign silence_db  = deb[NP];
   assign ack_db      = deb[NP+1];
   assign reset_db    = deb[NP+2];
   assign test_db     = deb[NP+3];
   assign reset_press = reset_db & ~reset_prev;
   assign ack_press   = (ack_db | silence_db) & ~ack_prev;

   // Polarity per point, test forces every point active
   assign trouble = (contact_db ^ i_alarm_on_open) | {NP{test_db}};  // [RQ2] [RQ11]

   ////////////////////////////////////////////////////////////////////////////
   // Common flash timebase
   logic [FW-1:0] flash_cnt;
   logic [FW-1:0] next_flash_cnt;
   logic          flash_ph;
   logic          next_flash_ph;

   // Half-period counter toggles one shared phase
   always_comb begin
      next_flash_cnt = flash_cnt + FW'(1);
      next_flash_ph  = flash_ph;
      if (flash_cnt == FW'(FLASH_CYC - 1)) begin
         next_flash_cnt = '0;
         next_flash_ph  = ~flash_ph;  // [RQ17]
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         flash_cnt  <= '0;
         flash_ph   <= 1'b1;
         reset_prev <= 1'b0;
         ack_prev   <= 1'b0;
      end else begin
         flash_cnt  <= next_flash_cnt;
         flash_ph   <= next_flash_ph;
         reset_prev <= reset_db;
         ack_prev   <= ack_db | silence_db;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-point sequence state
   aas_state_e    pt_state [NP];
   aas_state_e    next_pt_state [NP];
   logic [NP-1:0] new_alert;
   logic [NP-1:0] pt_cleared;

   // Each point advances only from its own input and edge-detected buttons
   always_comb begin
      new_alert  = '0;
      pt_cleared = '0;
      for (int p = 0; p < NP; p++) begin
         next_pt_state[p] = pt_state[p];  // [RQ1] [RQ9]
         unique case (pt_state[p])
            AAS_NORMAL: begin
               if (trouble[p]) begin
                  next_pt_state[p] = AAS_ALERT;  // [RQ4]
                  new_alert[p]     = 1'b1;
               end
            end
            AAS_ALERT: begin  // Stays alerting if trouble clears; reset ignored
               if (ack_press) begin
                  next_pt_state[p] = AAS_ACKED;  // [RQ5] [RQ7] [RQ10]
               end
            end
            AAS_ACKED: begin
               if (reset_press && !trouble[p]) begin
                  next_pt_state[p] = AAS_NORMAL;  // [RQ6] [RQ8]
                  pt_cleared[p]    = 1'b1;
               end
            end
            default: next_pt_state[p] = AAS_NORMAL;  // Illegal code recovers
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      for (int p = 0; p < NP; p++) begin
         if (!i_reset_n) begin
            pt_state[p] <= AAS_NORMAL;
         end else begin
            pt_state[p] <= next_pt_state[p];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lamp, pilot and horn outputs
   logic [NP-1:0] next_lamp;
   logic          next_pilot;
   logic          next_horn;

   // Alerting points flash, acknowledged points steady
   always_comb begin
      next_lamp  = '0;
      next_pilot = 1'b0;
      for (int p = 0; p < NP; p++) begin
         if (next_pt_state[p] == AAS_ALERT) begin
            next_lamp[p] = next_flash_ph;  // [RQ4] [RQ17]
            next_pilot   = 1'b1;
         end else if (next_pt_state[p] == AAS_ACKED) begin
            next_lamp[p] = 1'b1;  // [RQ5] [RQ6]
         end
      end
      // Horn only follows alerting points, never the reset button
      next_horn = next_pilot;  // [RQ8] [RQ14]
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         o_lamp       <= '0;
         o_pilot_lamp <= 1'b0;
         o_horn_relay <= 1'b0;
      end else begin
         o_lamp       <= next_lamp;
         o_pilot_lamp <= next_pilot;
         o_horn_relay <= next_horn;  // [RQ14]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event history writer: one event per cycle, lowest point first
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW:0]      ev_count;
   logic [AW:0]      next_ev_count;
   logic [NP-1:0]    ev_pend;
   logic [NP-1:0]    next_ev_pend;
   logic [NP-1:0]    ev_kind_clr;
   logic [NP-1:0]    next_ev_kind_clr;
   logic             ev_we;
   logic [EVT_W-1:0] ev_data;
   logic [PW-1:0]    ev_pt;
   // Pending events, lowest point written first, pointer and count
   always_comb begin
      next_ev_pend     = ev_pend | new_alert | pt_cleared;
      next_ev_kind_clr = (ev_kind_clr & ~new_alert) | pt_cleared;
      ev_we            = 1'b0;
      ev_pt            = '0;
      for (int p = NP - 1; p >= 0; p--) begin
         if (ev_pend[p]) begin
            ev_pt = PW'(p);
            ev_we = 1'b1;
         end
      end
      ev_data = {EVT_RESERVED, ev_kind_clr[ev_pt] ? EVT_KIND_RESET : EVT_KIND_ALERT,
                 ev_pt};
      next_wr_ptr   = wr_ptr;
      next_ev_count = ev_count;
      if (ev_we) begin
         // Set of a new event beats the clear of the one written
         next_ev_pend[ev_pt] = new_alert[ev_pt] | pt_cleared[ev_pt];
         next_wr_ptr         = wr_ptr + AW'(1);  // [RQ12]
         if (ev_count != (AW + 1)'(DEPTH)) begin
            next_ev_count = ev_count + (AW + 1)'(1);
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         wr_ptr        <= '0;
         ev_count      <= '0;
         ev_pend       <= '0;
         ev_kind_clr   <= '0;
         o_event_count <= '0;
      end else begin
         wr_ptr        <= next_wr_ptr;
         ev_count      <= next_ev_count;
         ev_pend       <= next_ev_pend;
         ev_kind_clr   <= next_ev_kind_clr;
         o_event_count <= next_ev_count;
      end
   end

   // Two registered read ports: panel and serial, index 0 is newest
   aas_event_mem #(
      .DEPTH (DEPTH),
      .WIDTH (EVT_W),
      .AW    (AW)
   ) u_mem (
      .i_clk_sys (i_clk_sys),
      .i_we      (ev_we),
      .i_waddr   (wr_ptr),
      .i_wdata   (ev_data),
      .i_raddr_a (slot_addr(wr_ptr, i_panel_idx)),   // [RQ13]
      .o_rdata_a (o_panel_event),
      .i_raddr_b (slot_addr(wr_ptr, i_serial_idx)),  // [RQ13]
      .o_rdata_b (o_serial_event)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Self supervision: supply, flash heartbeat, illegal point state
   logic [FW:0] hb_cnt;
   logic [FW:0] next_hb_cnt;
   logic        next_sup_fault;
   logic        bad_state;
   // Fault on supply loss, stalled flash or illegal point state
   always_comb begin
      bad_state = 1'b0;
      for (int p = 0; p < NP; p++) begin
         if (!(pt_state[p] inside {AAS_NORMAL, AAS_ALERT, AAS_ACKED})) begin
            bad_state = 1'b1;
         end
      end
      next_hb_cnt = (flash_ph != next_flash_ph) ? '0 : hb_cnt + (FW + 1)'(1);
      if (hb_cnt == '1) begin
         next_hb_cnt = hb_cnt;
      end
      next_sup_fault = ~i_psu_ok | bad_state |
                       (hb_cnt > (FW + 1)'(FLASH_CYC));  // [RQ15]
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         hb_cnt      <= '0;
         o_sup_fault <= 1'b0;
      end else begin
         hb_cnt      <= next_hb_cnt;
         o_sup_fault <= next_sup_fault;  // [RQ15]
      end
   end
endmodule : aas_sequencer

/* File: sim/aas_field_model.sv */
// Model of the field trouble contacts and operator pushbuttons.
// Assumes the bench sets wanted levels shortly after a rising clock edge.
`timescale 1ns/1ps
module aas_field_model (
   input  wire logic        i_clk_sys,
   input  wire logic [19:0] i_level,
   input  wire logic [15:0] i_alarm_on_open,
   output logic      [15:0] o_contact,
   output logic      [3:0]  o_pb
);
   logic [19:0] lvl_q = 20'h00000;
   logic [19:0] chg   = 20'h00000;
   logic [19:0] raw;
   logic [1:0]  bnc   = 2'h0;
   ////////////////////////////////////////////////////////////////////////////////
   // Every change bounces back once before it settles
   always_ff @(posedge i_clk_sys) begin
      lvl_q <= i_level;
      if (lvl_q != i_level) begin
         chg <= lvl_q ^ i_level;
         bnc <= 2'h3;
      end else if (bnc != 2'h0) begin
         bnc <= bnc - 2'h1;
      end
      raw <= lvl_q ^ (bnc[0] ? chg : 20'h00000);
   end
   // Open-for-alarm points see the contact inverted
   assign o_contact = raw[15:0] ^ i_alarm_on_open;
   assign o_pb      = raw[19:16];
endmodule : aas_field_model

/* File: sim/aas_seq_monitor.sv */
// Port checker for the annunciator sequencer.
// Assumes it is bound to every sequencer instance.
`timescale 1ns/1ps
module aas_seq_monitor
   import aas_pkg::*;
#(
   parameter int unsigned NP        = NUM_POINTS,
   parameter int unsigned DEB_CYC   = DEBOUNCE_CYC,
   parameter int unsigned FLASH_CYC = FLASH_HALF_CYC,
   parameter int unsigned DEPTH     = EVENT_DEPTH,
   parameter int unsigned AW        = $clog2(DEPTH)
) (
   input wire logic             i_clk_sys,
   input wire logic             i_reset_n,
   input wire logic [NP-1:0]    i_contact,
   input wire logic [NP-1:0]    i_alarm_on_open,
   input wire logic             i_pb_silence,
   input wire logic             i_pb_ack,
   input wire logic             i_pb_lamp_reset,
   input wire logic             i_pb_lamp_test,
   input wire logic             i_psu_ok,
   input wire logic [AW-1:0]    i_panel_idx,
   input wire logic [AW-1:0]    i_serial_idx,
   input wire logic [NP-1:0]    o_lamp,
   input wire logic             o_pilot_lamp,
   input wire logic             o_horn_relay,
   input wire logic             o_sup_fault,
   input wire logic [EVT_W-1:0] o_panel_event,
   input wire logic [EVT_W-1:0] o_serial_event,
   input wire logic [AW:0]      o_event_count
);
   logic [4:0]  quiet_cnt;
   logic [31:0] still_cnt;
   ////////////////////////////////////////////////////////////////////////////////
   // Cycles since a cause of alert; cycles of unchanged lamps while alerting
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n || $changed(i_contact) || $changed(i_alarm_on_open)
          || $rose(i_pb_lamp_test)) begin
         quiet_cnt <= 5'h00;
      end else if (quiet_cnt != 5'h1F) begin
         quiet_cnt <= quiet_cnt + 5'h01;
      end
      if (!i_reset_n || !o_pilot_lamp || $changed(o_lamp)) begin
         still_cnt <= 32'h00000000;
      end else begin
         still_cnt <= still_cnt + 32'h00000001;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   // Clean presses held long enough to pass the debouncer
   sequence s_test_press;
      ($rose(i_pb_lamp_test) && o_lamp == '0 && !o_pilot_lamp)
         ##1 (i_pb_lamp_test && !i_pb_ack && !i_pb_silence)[*8];
   endsequence
   sequence s_ack_press;
      $rose(i_pb_ack || i_pb_silence) ##1 (i_pb_ack || i_pb_silence)[*8];
   endsequence
   a_horn_follows_pilot: assert property (o_horn_relay == o_pilot_lamp)
      else $error("horn differs from pilot");
   a_dark_after_reset: assert property ($rose(i_reset_n) |->
      o_lamp == '0 && !o_pilot_lamp && !o_horn_relay && o_event_count == '0)
      else $error("outputs not dark after reset");
   a_test_alerts: assert property (s_test_press |-> ##[0:4] (o_pilot_lamp && o_horn_relay))
      else $error("lamp test gave no alert");
   a_ack_silences: assert property (s_ack_press ##0 (quiet_cnt == 5'h1F) |->
      !o_horn_relay && !o_pilot_lamp)
      else $error("acknowledge left horn on");
   a_horn_needs_cause: assert property ($rose(o_horn_relay) |-> quiet_cnt <= 5'd12)
      else $error("horn rose without new trouble");
   a_flash_rate: assert property (still_cnt < FLASH_CYC)
      else $error("flashing lamps stopped toggling");
   a_psu_fault: assert property (!i_psu_ok |-> ##[1:3] o_sup_fault)
      else $error("supply failure not flagged");
   a_count_steps: assert property ($changed(o_event_count) |->
      o_event_count == $past(o_event_count) + 1'b1)
      else $error("event count jumped");
   a_count_limit: assert property (o_event_count <= DEPTH)
      else $error("event count above depth");
endmodule : aas_seq_monitor
bind aas_sequencer aas_seq_monitor #(.NP(NP), .DEB_CYC(DEB_CYC), .FLASH_CYC(FLASH_CYC),
   .DEPTH(DEPTH), .AW(AW)) i_aas_seq_monitor (.*);

/* File: sim/tb_top.sv */
// Self-checking bench for the annunciator sequencer.
// Assumes short debounce and flash counts; field model in front of the inputs.
`timescale 1ns/1ps
module tb_top;
   import aas_pkg::*;
   localparam int unsigned DEB = 4;
   localparam int unsigned FLS = 8;
   typedef struct packed {
      logic [15:0] alm;
      logic [3:0]  btn;
      logic [15:0] stdy;
      logic [15:0] fl;
   } aas_row_s;
   // Alarms, buttons {test,reset,ack,silence}, steady lamps, flashing lamps
   localparam aas_row_s ROWS [18] = '{
      '{16'h0001, 4'h0, 16'h0000, 16'h0001}, '{16'h0003, 4'h0, 16'h0000, 16'h0003},
      '{16'h0002, 4'h0, 16'h0000, 16'h0003}, '{16'h0002, 4'h2, 16'h0003, 16'h0000},
      '{16'h0002, 4'h0, 16'h0003, 16'h0000}, '{16'h0002, 4'h4, 16'h0002, 16'h0000},
      '{16'h0002, 4'h0, 16'h0002, 16'h0000}, '{16'h8002, 4'h0, 16'h0002, 16'h8000},
      '{16'h8002, 4'h1, 16'h8002, 16'h0000}, '{16'h0000, 4'h0, 16'h8002, 16'h0000},
      '{16'h0000, 4'h7, 16'h0000, 16'h0000}, '{16'h0000, 4'h0, 16'h0000, 16'h0000},
      '{16'h0000, 4'h8, 16'h0000, 16'hFFFF}, '{16'h0000, 4'h0, 16'h0000, 16'hFFFF},
      '{16'h0000, 4'h2, 16'hFFFF, 16'h0000}, '{16'h0000, 4'h0, 16'hFFFF, 16'h0000},
      '{16'h0000, 4'h4, 16'h0000, 16'h0000}, '{16'h0000, 4'h0, 16'h0000, 16'h0000}};
   logic        clk = 1'b0;
   logic        rst_n;
   logic        psu_ok;
   logic [19:0] level;
   logic [15:0] pol;
   logic [15:0] contact;
   logic [3:0]  pb;
   logic [2:0]  pidx;
   logic [2:0]  sidx;
   logic [15:0] lamp;
   logic        pilot;
   logic        horn;
   logic        fault;
   logic [7:0]  pev;
   logic [7:0]  sev;
   logic [3:0]  cnt;
   logic [15:0] l0;
   int          miscompares = 0;
   int          n_tests = 0;
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #25 clk = ~clk;
   end
   aas_field_model i_aas_field_model (.i_clk_sys(clk), .i_level(level),
      .i_alarm_on_open(pol), .o_contact(contact), .o_pb(pb));
   aas_sequencer #(.DEB_CYC(DEB), .FLASH_CYC(FLS)) i_aas_sequencer (
      .i_clk_sys(clk), .i_reset_n(rst_n), .i_contact(contact), .i_alarm_on_open(pol),
      .i_pb_silence(pb[0]), .i_pb_ack(pb[1]), .i_pb_lamp_reset(pb[2]),
      .i_pb_lamp_test(pb[3]), .i_psu_ok(psu_ok), .i_panel_idx(pidx), .i_serial_idx(sidx),
      .o_lamp(lamp), .o_pilot_lamp(pilot), .o_horn_relay(horn), .o_sup_fault(fault),
      .o_panel_event(pev), .o_serial_event(sev), .o_event_count(cnt));
   ////////////////////////////////////////////////////////////////////////////////
   // Wait whole cycles, then step just past the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : cyc
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      psu_ok = 1'b1;
      level = 20'h00000;
      pol = 16'h0F0F;
      pidx = 3'h0;
      sidx = 3'h7;
      cyc(16);
      rst_n = 1'b1;
      // Sequence table: pilot follows any flashing point
      foreach (ROWS[r]) begin
         level = {ROWS[r].btn, ROWS[r].alm};
         cyc(16);
         l0 = lamp;
         chk(16'(pilot), 16'(|ROWS[r].fl));
         chk(16'(horn), 16'(|ROWS[r].fl));
         chk(l0 & ~ROWS[r].fl, ROWS[r].stdy);
         chk(l0 & ROWS[r].fl, (l0 & ROWS[r].fl) != 16'h0000 ? ROWS[r].fl : 16'h0000);
         cyc(FLS);
         chk(lamp & ROWS[r].fl, ~l0 & ROWS[r].fl);
         $display("row %0d done", r);
      end
      // History: newest and oldest held entries, both from the last reset burst
      cyc(2);
      chk(16'(pev), 16'({EVT_RESERVED, EVT_KIND_RESET, 4'hF}));
      chk(16'(sev), 16'({EVT_RESERVED, EVT_KIND_RESET, 4'h8}));
      chk(16'(cnt), 16'(EVENT_DEPTH));
      $display("history test done");
      // Supply failure flagged within a bounded wait
      psu_ok = 1'b0;
      for (int k = 0; k < 4 && fault !== 1'b1; k++) cyc(1);
      chk(16'(fault), 16'h0001);
      // A fault flag that never came skips straight to the report
      if (fault === 1'b1) begin
         psu_ok = 1'b1;
         $display("supervision test done");
         // Reset in mid-alarm, then the alarm is seen afresh
         level = 20'h00010;
         sidx = 3'h0;
         cyc(16);
         rst_n = 1'b0;
         cyc(16);
         chk(lamp, 16'h0000);
         chk(16'({pilot, horn, fault, cnt}), 16'h0000);
         rst_n = 1'b1;
         cyc(16);
         chk(16'(horn), 16'h0001);
         chk(16'(cnt), 16'h0001);
         chk(16'(pev), 16'({EVT_RESERVED, EVT_KIND_ALERT, 4'h4}));
         chk(16'(sev), 16'({EVT_RESERVED, EVT_KIND_ALERT, 4'h4}));
         $display("reset test done");
      end
      print_verdict();
   end
endmodule : tb_top
